// ---- hw/fbp_pkg.sv ----
/*
  fbp_pkg: constants, states and carriers of the flyback protection sequencer.
  Assumes a 200 MHz core clock; analog levels arrive as comparator bits or codes.
*/
`default_nettype none
package fbp_pkg;
  // clock
  localparam int CLK_PERIOD_NS = 5;
  // timing figures in their own unit
  localparam int T_MAX_ON_NS    = 38500;
  localparam int T_DEMAG_SUP_NS = 2200;
  localparam int T_ON_MIN_NS    = 500;
  localparam int T_DRV_DLY_NS   = 100;
  // longest time rounds down, least times round up
  localparam int MAX_ON_CYC    = T_MAX_ON_NS / CLK_PERIOD_NS;
  localparam int DEMAG_SUP_CYC = (T_DEMAG_SUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LEB_NS        = T_ON_MIN_NS - T_DRV_DLY_NS;
  localparam int LEB_CYC       = (LEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // overvoltage event counter
  localparam int       OVP_CW     = 3;
  localparam bit [2:0] OVP_UP     = 3'h1;
  localparam bit [2:0] OVP_DOWN   = 3'h2;
  localparam bit [2:0] OVP_TRIP   = 3'h6;
  localparam bit [2:0] OVP_ZERO   = 3'h0;
  localparam int       OVP_FILT_W = 4;
  localparam bit [3:0] OVP_FILT_N = 4'h8;
  // sense codes and overpower compensation
  localparam int       CODE_W    = 8;
  localparam bit [7:0] OPP_MAX   = 8'hFF;
  localparam int       OPP_SHIFT = 1;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SOFT, ST_WAIT, ST_ON, ST_SEC, ST_RESTART
  } fbp_state_e;

  typedef struct packed {
    logic supply_ok;   // supply at start-up threshold
    logic ss_level;    // primary_current_sense at soft-start level
    logic ovp_trip;    // aux_winding_sense above overvoltage trip
    logic demag_end;   // demagnetization detector: stroke ended
    logic cycle_req;   // oscillator/valley asks for a new stroke
  } fbp_sense_s;

  typedef struct packed {
    logic           soft_start_en;
    logic           soft_start_limit;
    logic           safe_restart;
    logic [2:0]     ovp_count;
  } fbp_status_s;
endpackage : fbp_pkg
`default_nettype wire

// ---- hw/fbp_sequencer.sv ----
/*
  fbp_sequencer: start-up, soft-start, on-time, overcurrent, overpower and
  overvoltage sequencing for the flyback primary switch.
  Assumes comparator bits and sense codes synchronous to core_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module fbp_sequencer #(
  parameter int MAX_ON   = fbp_pkg::MAX_ON_CYC,
  parameter int LEB      = fbp_pkg::LEB_CYC,
  parameter int DEMAG_SP = fbp_pkg::DEMAG_SUP_CYC
) (
  input  wire logic                        core_clk_i,
  input  wire logic                        resetn_i,
  input  wire fbp_pkg::fbp_sense_s         sense_i,
  input  wire logic [fbp_pkg::CODE_W-1:0]  primary_current_sense_i,
  input  wire logic [fbp_pkg::CODE_W-1:0]  feedback_control_voltage_i,
  input  wire logic [fbp_pkg::CODE_W-1:0]  aux_winding_sense_i,
  output logic                             flyback_gate_drive_o,
  output fbp_pkg::fbp_status_s             status_o
);
  import fbp_pkg::*;

  localparam int CW = 16;

  if (MAX_ON <= LEB || MAX_ON >= (1 << CW) || LEB < 1 || DEMAG_SP < 1 ||
      DEMAG_SP >= (1 << CW)) begin : g_chk
    $error("fbp_sequencer: timing parameters out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state and counters

  fbp_state_e          st_r;
  fbp_state_e          st_nxt;
  logic [CW-1:0]       on_cnt_r;
  logic [CW-1:0]       sec_cnt_r;
  logic [OVP_FILT_W-1:0] filt_r;
  logic                ovp_hit_r;
  logic [OVP_CW-1:0]   ovp_cnt_r;
  logic [OVP_CW-1:0]   ovp_cnt_nxt;
  logic [CODE_W-1:0]   line_r;
  logic                gate_r;
  fbp_status_s         stat_r;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  wire        blanked   = on_cnt_r < CW'(LEB);
  wire        at_max    = on_cnt_r == CW'(MAX_ON - 1);
  wire        demag_ok  = sec_cnt_r >= CW'(DEMAG_SP);
  wire        end_sec   = (st_r == ST_SEC) && demag_ok && sense_i.demag_end;

  // higher input voltage, lower peak limit
  wire [CODE_W-1:0] opp_limit = OPP_MAX - (line_r >> OPP_SHIFT);
  wire [CODE_W-1:0] pk_limit  = (feedback_control_voltage_i < opp_limit) ?
                                feedback_control_voltage_i : opp_limit;
  wire        pk_reached = primary_current_sense_i >= pk_limit;
  wire        ocp_trip   = (st_r == ST_ON) && !blanked && pk_reached;

  // one up on an overvoltage cycle
  wire [OVP_CW-1:0] cnt_up = (ovp_cnt_r >= OVP_TRIP) ? OVP_TRIP : ovp_cnt_r + OVP_UP;
  // two down on a clean cycle
  wire [OVP_CW-1:0] cnt_dn = (ovp_cnt_r < OVP_DOWN) ? OVP_ZERO : ovp_cnt_r - OVP_DOWN;
  wire [OVP_CW-1:0] cnt_upd = ovp_hit_r ? cnt_up : cnt_dn;
  wire        ovp_fault = end_sec && (cnt_upd >= OVP_TRIP);

  ////////////////////////////////////////////////////////////////////////////
  // sequencing

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        // start-up level starts the soft-start phase
        if (sense_i.supply_ok) begin
          st_nxt = ST_SOFT;
        end
      end
      ST_SOFT: begin
        // switching waits for the soft-start level
        if (sense_i.ss_level) begin
          st_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (sense_i.cycle_req) begin
          st_nxt = ST_ON;
        end
      end
      ST_ON: begin
        // overlong stroke goes to safe restart
        if (ocp_trip) begin
          st_nxt = ST_SEC;
        end else if (at_max) begin
          st_nxt = ST_RESTART;
        end
      end
      ST_SEC: begin
        if (ovp_fault) begin
          st_nxt = ST_RESTART;
        end else if (end_sec) begin
          st_nxt = ST_WAIT;
        end
      end
      ST_RESTART: begin
        // stays off until the supply drops below start-up and comes back
        if (!sense_i.supply_ok) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  // cleared at start-up and on entry to restart
  // single update at the end of each secondary stroke
  always_comb begin
    ovp_cnt_nxt = ovp_cnt_r;
    if (st_nxt == ST_RESTART || st_r == ST_IDLE) begin
      ovp_cnt_nxt = OVP_ZERO;
    end else if (end_sec) begin
      ovp_cnt_nxt = cnt_upd;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      st_r <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // on-time, secondary stroke and measurement

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      on_cnt_r  <= '0;
      sec_cnt_r <= '0;
      line_r    <= '0;
    end else begin
      // on-time counter runs only with the gate on
      on_cnt_r  <= (st_r == ST_ON && st_nxt == ST_ON) ? on_cnt_r + CW'(1) : '0;
      // suppression window counted from stroke start
      sec_cnt_r <= (st_r == ST_SEC && !demag_ok) ? sec_cnt_r + CW'(1) :
                   (st_r == ST_SEC) ? sec_cnt_r : '0;
      // line measurement tracked during the primary stroke
      if (st_r == ST_ON) begin
        line_r <= aux_winding_sense_i;
      end
    end
  end

  // filter: up/down on the trip bit, only in the secondary stroke
  // isolated spikes shorter than the filter depth never register
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      filt_r    <= '0;
      ovp_hit_r <= 1'b0;
    end else if (st_r != ST_SEC) begin
      filt_r    <= '0;
      ovp_hit_r <= 1'b0;
    end else begin
      if (sense_i.ovp_trip && filt_r != OVP_FILT_N) begin
        filt_r <= filt_r + OVP_FILT_W'(1);
      end else if (!sense_i.ovp_trip && filt_r != '0) begin
        filt_r <= filt_r - OVP_FILT_W'(1);
      end
      if (filt_r == OVP_FILT_N) begin
        ovp_hit_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all registered, all but soft_start_limit from next-state values

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      ovp_cnt_r <= OVP_ZERO;
      gate_r    <= 1'b0;
      stat_r    <= '0;
    end else begin
      ovp_cnt_r               <= ovp_cnt_nxt;
      // gate drops when the on-time bound is reached
      gate_r                  <= st_nxt == ST_ON;
      stat_r.soft_start_en    <= st_nxt == ST_SOFT;
      stat_r.soft_start_limit <= (st_r == ST_SOFT) && sense_i.ss_level;
      stat_r.safe_restart     <= st_nxt == ST_RESTART;
      stat_r.ovp_count        <= ovp_cnt_nxt;
    end
  end

  assign flyback_gate_drive_o = gate_r;
  assign status_o             = stat_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [CW-1:0] run_r;
  logic          started_r;
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      run_r     <= '0;
      started_r <= 1'b0;
    end else begin
      run_r     <= gate_r ? run_r + CW'(1) : '0;
      // a fresh start-up from idle is the only way back to soft-start
      started_r <= (st_r != ST_IDLE) && (started_r || gate_r);
    end
  end

  chk_ss_enable: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (st_r == ST_IDLE && sense_i.supply_ok) |=> status_o.soft_start_en)
    else $error("soft-start source not enabled at start-up");

  chk_gate_hold: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    status_o.soft_start_en |-> !flyback_gate_drive_o ##1 !flyback_gate_drive_o)
    else $error("gate driven during soft-start");

  chk_ss_limit: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    status_o.soft_start_limit |-> $past(sense_i.ss_level) && !status_o.soft_start_en)
    else $error("soft-start limit without level");

  chk_ss_off: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    started_r |-> !status_o.soft_start_en)
    else $error("soft-start source back on after switching");

  chk_max_on: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    flyback_gate_drive_o |-> run_r < CW'(MAX_ON))
    else $error("on period beyond bound");

  chk_max_restart: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (flyback_gate_drive_o && run_r == CW'(MAX_ON - 1) && !pk_reached) |=>
      status_o.safe_restart && !flyback_gate_drive_o)
    else $error("no safe restart after overlong stroke");

  chk_ovp_window: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    $rose(ovp_hit_r) |-> $past(st_r) == ST_SEC && $past(filt_r) == OVP_FILT_N)
    else $error("overvoltage seen outside secondary stroke");

  chk_ovp_count: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (end_sec && !ovp_fault) |=> status_o.ovp_count ==
      ($past(ovp_hit_r) ? $past(ovp_cnt_r) + OVP_UP :
       ($past(ovp_cnt_r) < OVP_DOWN ? OVP_ZERO : $past(ovp_cnt_r) - OVP_DOWN)))
    else $error("overvoltage counter step wrong");

  chk_ovp_trip: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (end_sec && ovp_hit_r && ovp_cnt_r == OVP_TRIP - OVP_UP) |=>
      status_o.safe_restart ##1 !flyback_gate_drive_o)
    else $error("sixth overvoltage event missed");

  chk_ocp_end: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (st_r == ST_ON && run_r >= CW'(LEB) && pk_reached) |=> !flyback_gate_drive_o)
    else $error("peak current did not end on period");

  chk_leb_hold: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    $fell(flyback_gate_drive_o) |-> $past(run_r) >= CW'(LEB))
    else $error("gate ended inside blanking");

  chk_demag_wait: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (st_r == ST_SEC && !sense_i.demag_end) |=> !flyback_gate_drive_o)
    else $error("stroke started before demagnetization");

  chk_demag_sup: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (st_r == ST_SEC && sec_cnt_r < CW'(DEMAG_SP)) |=> st_r == ST_SEC)
    else $error("demagnetization accepted during suppression");

  chk_ovp_clear: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    status_o.safe_restart |-> status_o.ovp_count == OVP_ZERO)
    else $error("counter not cleared in restart");

  chk_ovp_once: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (!end_sec && st_r != ST_IDLE && st_nxt != ST_RESTART) |=> $stable(ovp_cnt_r))
    else $error("counter moved outside stroke end");

endmodule : fbp_sequencer
`default_nettype wire

// ---- tb/fbp_partner.sv ----
/*
  fbp_partner: behavioural switch, transformer and sense comparators.
  Assumes gate and charge come from the sequencer; drives at the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module fbp_partner #(
  parameter bit [7:0] SS_CHG = 8'h10
) (
  input  wire logic               core_clk_i,
  input  wire logic               gate_i,
  input  wire logic               charge_i,
  input  wire logic               supply_i,
  input  wire logic               ovp_i,
  input  wire logic [7:0]         vin_i,
  input  wire logic [7:0]         sec_len_i,
  output var  fbp_pkg::fbp_sense_s sense_o,
  output var  logic [7:0]         current_o,
  output var  logic [7:0]         aux_o
);
  import fbp_pkg::*;
  logic [7:0] chg_r = 8'h00;
  logic [7:0] sec_r = 8'hFF;
  initial begin
    sense_o = '0;
    current_o = 8'h00;
    aux_o = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////////////
  always @(negedge core_clk_i) begin
    // cap charges only while source on
    chg_r <= !supply_i ? 8'h00 : (charge_i && chg_r != 8'hFF) ? chg_r + 8'h01 : chg_r;
    sec_r <= gate_i ? 8'h00 : (sec_r == 8'hFF) ? sec_r : sec_r + 8'h01;
    current_o <= gate_i ? current_o + 8'h01 : 8'h00;
    // input voltage only in primary stroke
    aux_o <= gate_i ? vin_i : ~aux_o;
    sense_o.supply_ok <= supply_i;
    sense_o.ss_level <= chg_r >= SS_CHG;
    sense_o.ovp_trip <= ovp_i && !gate_i;
    // demag after sec_len cycles, early ringing end too
    sense_o.demag_end <= !gate_i && sec_r >= sec_len_i;
    sense_o.cycle_req <= !gate_i;
  end
endmodule // fbp_partner
`default_nettype wire

// ---- tb/fbp_sequencer_bench.sv ----
/*
  fbp_sequencer_bench: self-checking scenarios for the sequencer.
  Assumes fbp_partner as far side; short counts set by parameters.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; $display("BAD %0t mismatch", $time); end end
module fbp_sequencer_bench;
  import fbp_pkg::*;
  localparam int MAXON = 200;
  localparam int BLANK = 4;
  localparam int DSUP  = 8;
  logic        core_clk = 1'b0;
  logic        resetn   = 1'b0;
  logic        supply   = 1'b0;
  logic        ovp      = 1'b0;
  logic [7:0]  fb       = 8'h14;
  logic [7:0]  vin      = 8'h00;
  logic [7:0]  sec_len  = 8'h14;
  fbp_sense_s  sense;
  logic [7:0]  pcs;
  logic [7:0]  aux;
  logic        gate;
  fbp_status_s st;
  logic        lim_seen = 1'b0;
  int err_total = 0, n_tests = 0, on_r = 0, off_r = 0, last_on = 0, last_off = 0, rises = 0;

  always #2.5 core_clk = ~core_clk;

  fbp_sequencer #(.MAX_ON(MAXON), .LEB(BLANK), .DEMAG_SP(DSUP)) uut (
    .core_clk_i(core_clk), .resetn_i(resetn), .sense_i(sense), .primary_current_sense_i(pcs),
    .feedback_control_voltage_i(fb), .aux_winding_sense_i(aux), .flyback_gate_drive_o(gate), .status_o(st));
  fbp_partner u_part (
    .core_clk_i(core_clk), .gate_i(gate), .charge_i(st.soft_start_en), .supply_i(supply), .ovp_i(ovp),
    .vin_i(vin), .sec_len_i(sec_len), .sense_o(sense), .current_o(pcs), .aux_o(aux));

  // pre-edge values, so tasks at the falling edge see settled counts
  always @(posedge core_clk) begin
    if (gate === 1'b1) begin
      if (on_r == 0) begin
        rises++;
        last_off = off_r;
      end
      on_r++;
      off_r = 0;
    end else begin
      if (on_r != 0) last_on = on_r;
      on_r = 0;
      off_r++;
    end
    if (st.soft_start_limit === 1'b1) lim_seen = 1'b1;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_rises(input int k);
    int r0;
    r0 = rises;
    for (int i = 0; i < 2000 && rises < r0 + k; i++) @(negedge core_clk);
    `CHK(rises >= r0 + k, 1'b1)
  endtask
  task automatic wait_restart();
    for (int i = 0; i < 3000 && st.safe_restart !== 1'b1; i++) @(negedge core_clk);
    `CHK(st.safe_restart, 1'b1)
  endtask
  task automatic t_start();
    supply <= 1'b1;
    repeat (2) @(negedge core_clk);
    `CHK(st.soft_start_en, 1'b1)
    `CHK(gate, 1'b0)
    `CHK(st.soft_start_limit, 1'b0)
    wait_rises(1);
    `CHK(lim_seen, 1'b1)
    `CHK(sense.ss_level, 1'b1)
    `CHK(st.soft_start_en, 1'b0)
  endtask
  task automatic t_ocp();
    wait_rises(2);
    `CHK(last_on inside {[20:23]}, 1'b1)
    `CHK(last_off inside {[20:25]}, 1'b1)
    fb <= 8'h01;
    wait_rises(2);
    `CHK(last_on inside {[BLANK:BLANK+3]}, 1'b1)
    sec_len <= 8'h02;
    wait_rises(2);
    `CHK(last_off inside {[DSUP:DSUP+5]}, 1'b1)
    sec_len <= 8'h14;
  endtask
  task automatic t_opp();
    int exp;
    exp = 255 - (192 >> OPP_SHIFT);
    fb <= 8'hFF;
    vin <= 8'hC0;
    wait_rises(2);
    `CHK(last_on inside {[exp:exp+3]}, 1'b1)
    `CHK(st.soft_start_en, 1'b0)
  endtask
  task automatic t_ovp();
    int r0;
    fb <= 8'h14;
    vin <= 8'h00;
    wait_rises(2);
    `CHK(st.ovp_count, 3'h0)
    wait_rises(1);
    ovp <= 1'b1;
    for (int i = 1; i <= 3; i++) begin
      wait_rises(1);
      `CHK(st.ovp_count, 3'(i))
    end
    ovp <= 1'b0;
    wait_rises(1);
    `CHK(st.ovp_count, 3'h1)
    wait_rises(1);
    `CHK(st.ovp_count, 3'h0)
    ovp <= 1'b1;
    r0 = rises;
    wait_restart();
    `CHK(rises - r0, 5)
    `CHK(st.ovp_count, 3'h0)
  endtask
  task automatic t_recover();
    supply <= 1'b0;
    ovp <= 1'b0;
    repeat (4) @(negedge core_clk);
    `CHK(st.safe_restart, 1'b0)
    `CHK(st.ovp_count, 3'h0)
    supply <= 1'b1;
    wait_rises(1);
  endtask
  task automatic t_maxon();
    fb <= 8'hFF;
    wait_restart();
    repeat (2) @(negedge core_clk);
    `CHK(last_on, MAXON)
    `CHK(gate, 1'b0)
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    t_start();
    t_ocp();
    t_opp();
    t_ovp();
    t_recover();
    t_maxon();
    t_recover();
    conclude();
  end
  // whole run needs a few thousand cycles
  initial begin
    #(30000 * 5);
    err_total++;
    conclude();
  end
endmodule // fbp_sequencer_bench
`default_nettype wire
